//--- include/add_overhead_pkg.sv
package add_overhead_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index
  // ==========================================================
  localparam logic [7:0] test_v1_index        = 8'hcc;
  localparam logic [7:0] test_v2_index        = 8'hcd;
  localparam logic [7:0] n2_value_index       = 8'hd1;
  localparam logic [7:0] k4_value_index       = 8'hd2;
  localparam logic [7:0] overhead_ctrl_index  = 8'hd3;
  localparam logic [7:0] k4_mode_index        = 8'hd5;
  localparam logic [7:0] line_option_index    = 8'hd6;
  localparam logic [7:0] status_index         = 8'hd7;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] test_v1_reset        = 8'h00;
  localparam logic [7:0] test_v2_reset        = 8'h00;
  localparam logic [7:0] n2_value_reset       = 8'h00;
  localparam logic [7:0] k4_value_reset       = 8'h00;
  localparam logic [7:0] overhead_ctrl_reset  = 8'h00;
  localparam logic [7:0] k4_mode_reset        = 8'h00;
  localparam logic [7:0] line_option_reset    = 8'h00;

  // ==========================================================
  // Overhead control fields
  // ==========================================================
  localparam int tandem_ais_force_bit              = 7;
  localparam int tributary_ais_force_bit           = 6;
  localparam int test_pointer_select_bit           = 5;
  localparam int unequipped_generate_bit           = 4;
  localparam int unequipped_supervisory_select_bit = 3;
  localparam int tandem_connection_enable_bit      = 2;

  // K4 mode and line option fields
  localparam int k4_processor_control_bit = 1;
  localparam int three_bit_rdi_bit        = 0;
  localparam int symmetric_clock_bit      = 1;
  localparam int tu11_select_bit          = 2;
  localparam int supervisory_v5_rdi_bit   = 3;

  // Bus bit positions of overhead bits (bus bit 7 is overhead bit 1)
  localparam int n2_tc_ais_pos = 4;
  localparam int v5_rdi_pos    = 0;

  // ==========================================================
  // Fixed pointer bytes
  // ==========================================================
  localparam logic [7:0] tu12_v1 = 8'h68;
  localparam logic [7:0] tu12_v2 = 8'h69;
  localparam logic [7:0] tu11_v1 = 8'h6c;
  localparam logic [7:0] tu11_v2 = 8'h4e;
  localparam logic [7:0] all_ones  = 8'hff;
  localparam logic [7:0] all_zeros = 8'h00;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    kind_payload = 4'h0,
    kind_v1      = 4'h1,
    kind_v2      = 4'h2,
    kind_v3      = 4'h3,
    kind_v4      = 4'h4,
    kind_v5      = 4'h5,
    kind_j2      = 4'h6,
    kind_n2      = 4'h7,
    kind_k4      = 4'h8
  } byte_kind_type;

  typedef enum logic [1:0] {
    mode_normal      = 2'b00,
    mode_unequipped  = 2'b01,
    mode_supervisory = 2'b11,
    mode_ais         = 2'b10
  } mode_type;

endpackage

//--- hw/tributary_add_overhead_insert.sv
// Notes on behaviour
// - Tandem disabled: sent N2 byte is the N2 register value.
// - Register bit 7 is overhead bit 1, bit 0 is overhead bit 8.
// - K4 processor control set: whole K4 register is sent.
// - Three-bit RDI outside supervisory: K4 bits 5-7 generated internally, register ignored.
// - Single-bit RDI: K4 bits 5-7 taken from the register.
// - Symmetric clock interface: K4 bits 1-2 supplied internally.
// - K4 bits 3, 4 and 8 always come from the register.
// - Tandem enabled and tandem AIS set: N2 bit 4 sent as one.
// - Tributary AIS sends all ones over the whole tributary.
// - Test pointer select sends test V1/V2 register values.
// - Test pointer never moves V5, overhead or payload positions.
// - Unequipped bit 0 is normal; 1 with supervisory 0 is unequipped.
// - Unequipped carries normal NDF, size 10/105 or 11/78 pointer.
// - Plain unequipped sends every non-pointer byte as zero.
// - Supervisory unequipped sends valid J2, V5 with BIP-2, label zero.
// - Supervisory unequipped sends N2 zero and zero payload.
// - Supervisory: V5 bit 8 and K4 bits 5-7 from processor values.
// - Control bit 3 selects supervisory, together with unequipped bit.
// - Tandem enable bit 2 low: tandem off, N2 from register.
`timescale 1ns/10ps
`default_nettype none

module tributary_add_overhead_insert (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Tributary stream from upstream mapper
  input  wire logic        add_in_valid,
  input  wire logic [3:0]  add_in_kind,
  input  wire logic [7:0]  add_in_byte,
  // Internally generated overhead bits
  input  wire logic [2:0]  rdi_k4_bits,
  input  wire logic [1:0]  symmetric_k4_bits,
  // Tributary stream to the add bus
  output logic             add_out_valid,
  output logic [3:0]       add_out_kind,
  output logic [7:0]       add_out_byte
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic                 hreadyout;
    logic                 hresp;
    logic [31:0]          hrdata;
    logic                 dp_write;
    logic [7:0]           dp_index;
    logic [7:0]           test_v1;
    logic [7:0]           test_v2;
    logic [7:0]           n2_value;
    logic [7:0]           k4_value;
    logic [7:0]           ctrl;
    logic [7:0]           k4_mode;
    logic [7:0]           line_option;
    add_overhead_pkg::mode_type mode;
    logic                 test_active;
    logic [1:0]           bip_acc;
    logic [1:0]           bip_last;
    logic                 out_valid;
    logic [3:0]           out_kind;
    logic [7:0]           out_byte;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic rst_meta_reg;
  logic rst_sync_reg;

  // ==========================================================
  // Reset release
  // ==========================================================
  // Two flops so release never lands close to a clock edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Next state
  // ==========================================================
  logic [7:0]                 addr_index;
  logic                       addr_take;
  add_overhead_pkg::mode_type req_mode;
  add_overhead_pkg::mode_type use_mode;
  logic                       use_test;
  logic                       at_v1;
  logic [7:0]                 b;
  logic [7:0]                 k4;
  logic [7:0]                 rd;

  always_comb begin
    state_next = state_reg;
    addr_index = haddr[9:2];
    addr_take  = hsel && htrans[1] && hready;
    b          = add_in_byte;
    k4         = 8'h00;
    rd         = 8'h00;

    // Data phase write; registers hold new value by the next edge
    // Unmapped indices drop the write; the bus still sees OKAY
    if (state_reg.dp_write) begin
      case (state_reg.dp_index)
        add_overhead_pkg::test_v1_index: begin
          state_next.test_v1 = hwdata[7:0];
        end
        add_overhead_pkg::test_v2_index: begin
          state_next.test_v2 = hwdata[7:0];
        end
        add_overhead_pkg::n2_value_index: begin
          state_next.n2_value = hwdata[7:0];
        end
        add_overhead_pkg::k4_value_index: begin
          state_next.k4_value = hwdata[7:0];
        end
        add_overhead_pkg::overhead_ctrl_index: begin
          state_next.ctrl = hwdata[7:0];
        end
        add_overhead_pkg::k4_mode_index: begin
          state_next.k4_mode = hwdata[7:0];
        end
        add_overhead_pkg::line_option_index: begin
          state_next.line_option = hwdata[7:0];
        end
        default: begin
        end
      endcase
    end

    // Address phase; read data reflects a write in the same cycle
    state_next.dp_write = addr_take && hwrite;
    state_next.dp_index = addr_index;
    case (addr_index)
      add_overhead_pkg::test_v1_index: begin
        rd = state_next.test_v1;
      end
      add_overhead_pkg::test_v2_index: begin
        rd = state_next.test_v2;
      end
      add_overhead_pkg::n2_value_index: begin
        rd = state_next.n2_value;
      end
      add_overhead_pkg::k4_value_index: begin
        rd = state_next.k4_value;
      end
      add_overhead_pkg::overhead_ctrl_index: begin
        rd = state_next.ctrl;
      end
      add_overhead_pkg::k4_mode_index: begin
        rd = state_next.k4_mode;
      end
      add_overhead_pkg::line_option_index: begin
        rd = state_next.line_option;
      end
      // Status is read only; writes to it are dropped
      add_overhead_pkg::status_index: begin
        rd = {1'b0, state_reg.bip_last, state_reg.test_active,
              2'b00, state_reg.mode};
      end
      default: begin
        rd = 8'h00;
      end
    endcase
    if (addr_take && !hwrite) begin
      state_next.hrdata = {24'h000000, rd};
    end

    // Mode request, AIS first
    if (state_reg.ctrl[add_overhead_pkg::tributary_ais_force_bit]) begin
      req_mode = add_overhead_pkg::mode_ais;
    end else if (!state_reg.ctrl[
                   add_overhead_pkg::unequipped_generate_bit]) begin
      req_mode = add_overhead_pkg::mode_normal;
    end else if (state_reg.ctrl[
                   add_overhead_pkg::unequipped_supervisory_select_bit])
    begin
      req_mode = add_overhead_pkg::mode_supervisory;
    end else begin
      req_mode = add_overhead_pkg::mode_unequipped;
    end

    // Mode changes only at V1 so a multiframe is never mixed
    at_v1    = add_in_valid &&
               (add_in_kind == add_overhead_pkg::kind_v1);
    use_mode = at_v1 ? req_mode : state_reg.mode;
    use_test = at_v1 ?
      state_reg.ctrl[add_overhead_pkg::test_pointer_select_bit] :
      state_reg.test_active;
    if (at_v1) begin
      state_next.mode        = req_mode;
      state_next.test_active = use_test;
    end

    // Trade-off: internal K4 bits taken live, not latched per frame
    // K4 composition; bus bit 7 is overhead bit 1, so no swap needed
    k4 = state_reg.k4_value;
    if (!state_reg.k4_mode[add_overhead_pkg::k4_processor_control_bit])
    begin
      if (use_mode == add_overhead_pkg::mode_supervisory) begin
        k4[3:1] = state_reg.k4_value[3:1];
      end else if (state_reg.line_option[
                     add_overhead_pkg::three_bit_rdi_bit]) begin
        k4[3:1] = rdi_k4_bits;
      end else begin
        k4[3:1] = state_reg.k4_value[3:1];
      end
      if (state_reg.line_option[add_overhead_pkg::symmetric_clock_bit])
      begin
        k4[7:6] = symmetric_k4_bits;
      end
    end else begin
      k4 = state_reg.k4_value;
    end

    // Byte substitution; positions follow the input stream unchanged
    case (add_in_kind)
      add_overhead_pkg::kind_v1: begin
        if (use_test) begin
          b = state_reg.test_v1;
        end else if (state_reg.line_option[
                       add_overhead_pkg::tu11_select_bit]) begin
          b = add_overhead_pkg::tu11_v1;
        end else begin
          b = add_overhead_pkg::tu12_v1;
        end
      end
      add_overhead_pkg::kind_v2: begin
        if (use_test) begin
          b = state_reg.test_v2;
        end else if (state_reg.line_option[
                       add_overhead_pkg::tu11_select_bit]) begin
          b = add_overhead_pkg::tu11_v2;
        end else begin
          b = add_overhead_pkg::tu12_v2;
        end
      end
      add_overhead_pkg::kind_n2: begin
        if (!state_reg.ctrl[
              add_overhead_pkg::tandem_connection_enable_bit]) begin
          b = state_reg.n2_value;
        end else if (state_reg.ctrl[
                       add_overhead_pkg::tandem_ais_force_bit]) begin
          b[add_overhead_pkg::n2_tc_ais_pos] = 1'b1;
        end
        if (use_mode == add_overhead_pkg::mode_supervisory) begin
          b = add_overhead_pkg::all_zeros;
        end
      end
      add_overhead_pkg::kind_k4: begin
        b = k4;
      end
      add_overhead_pkg::kind_v5: begin
        if (use_mode == add_overhead_pkg::mode_supervisory) begin
          // BIP of the previous multiframe, label zero
          b = {state_reg.bip_last, add_in_byte[5:4], 3'b000,
               state_reg.line_option[
                 add_overhead_pkg::supervisory_v5_rdi_bit]};
        end
      end
      default: begin
      end
    endcase

    // Mode overrides; pointers survive unequipped generation
    case (use_mode)
      add_overhead_pkg::mode_unequipped: begin
        if (add_in_kind != add_overhead_pkg::kind_v1 &&
            add_in_kind != add_overhead_pkg::kind_v2) begin
          b = add_overhead_pkg::all_zeros;
        end
      end
      add_overhead_pkg::mode_supervisory: begin
        if (add_in_kind == add_overhead_pkg::kind_payload ||
            add_in_kind == add_overhead_pkg::kind_v3 ||
            add_in_kind == add_overhead_pkg::kind_v4) begin
          b = add_overhead_pkg::all_zeros;
        end
      end
      add_overhead_pkg::mode_ais: begin
        b = add_overhead_pkg::all_ones;
      end
      default: begin
      end
    endcase

    // Limitation: first multiframe after reset reports a zero BIP
    // BIP-2 over sent bytes except V1 to V4, closed at each V1
    if (add_in_valid) begin
      if (at_v1) begin
        state_next.bip_last = state_reg.bip_acc;
        state_next.bip_acc  = 2'b00;
      end else if (add_in_kind != add_overhead_pkg::kind_v2 &&
                   add_in_kind != add_overhead_pkg::kind_v3 &&
                   add_in_kind != add_overhead_pkg::kind_v4) begin
        state_next.bip_acc[1] = state_reg.bip_acc[1] ^
                                (b[7] ^ b[5] ^ b[3] ^ b[1]);
        state_next.bip_acc[0] = state_reg.bip_acc[0] ^
                                (b[6] ^ b[4] ^ b[2] ^ b[0]);
      end
    end

    // Idle cycles drive zero so the add bus never sees stale data
    // One-cycle pipeline to the add bus
    state_next.out_valid = add_in_valid;
    state_next.out_kind  = add_in_kind;
    state_next.out_byte  = add_in_valid ? b : add_overhead_pkg::all_zeros;
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Bus response bits never change: zero wait states, always OKAY
  always_ff @(posedge core_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg.hreadyout   <= 1'b1;
      state_reg.hresp       <= 1'b0;
      state_reg.hrdata      <= 32'h00000000;
      state_reg.dp_write    <= 1'b0;
      state_reg.dp_index    <= 8'h00;
      state_reg.test_v1     <= add_overhead_pkg::test_v1_reset;
      state_reg.test_v2     <= add_overhead_pkg::test_v2_reset;
      state_reg.n2_value    <= add_overhead_pkg::n2_value_reset;
      state_reg.k4_value    <= add_overhead_pkg::k4_value_reset;
      state_reg.ctrl        <= add_overhead_pkg::overhead_ctrl_reset;
      state_reg.k4_mode     <= add_overhead_pkg::k4_mode_reset;
      state_reg.line_option <= add_overhead_pkg::line_option_reset;
      state_reg.mode        <= add_overhead_pkg::mode_normal;
      state_reg.test_active <= 1'b0;
      state_reg.bip_acc     <= 2'b00;
      state_reg.bip_last    <= 2'b00;
      state_reg.out_valid   <= 1'b0;
      state_reg.out_kind    <= 4'h0;
      state_reg.out_byte    <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Every output comes straight from the state register
  assign hreadyout     = state_reg.hreadyout;
  assign hresp         = state_reg.hresp;
  assign hrdata        = state_reg.hrdata;
  assign add_out_valid = state_reg.out_valid;
  assign add_out_kind  = state_reg.out_kind;
  assign add_out_byte  = state_reg.out_byte;

endmodule

`default_nettype wire

//--- verif/add_bus_sink.sv
`timescale 1ns/10ps
`default_nettype none

module add_bus_sink (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Tributary stream from the block
  input  wire logic       add_out_valid,
  input  wire logic [3:0] add_out_kind,
  // Multiframes seen downstream
  output logic [15:0]     v1_seen
);
  // ==========================================
  // Multiframe count, never stalls the stream
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      v1_seen <= 16'h0000;
    end else if (add_out_valid && add_out_kind == 4'h1) begin
      v1_seen <= v1_seen + 16'h0001;
    end
  end
endmodule

`default_nettype wire

//--- verif/add_overhead_checker.sv
`timescale 1ns/10ps
`default_nettype none

module add_overhead_checker (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Stream
  input  wire logic        add_in_valid,
  input  wire logic [3:0]  add_in_kind,
  input  wire logic [7:0]  add_in_byte,
  input  wire logic [2:0]  rdi_k4_bits,
  input  wire logic [1:0]  symmetric_k4_bits,
  input  wire logic        add_out_valid,
  input  wire logic [3:0]  add_out_kind,
  input  wire logic [7:0]  add_out_byte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Register shadow
  logic [7:0] sh_reg [0:255];
  logic [7:0] wr_idx_reg;
  logic       wr_pend_reg;
  logic       settled_reg;
  wire        take = hsel & htrans[1] & hready;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) sh_reg[i] <= 8'h00;
      wr_idx_reg  <= 8'h00;
      wr_pend_reg <= 1'b0;
      settled_reg <= 1'b0;
    end else begin
      wr_pend_reg <= take & hwrite;
      wr_idx_reg  <= haddr[9:2];
      if (wr_pend_reg) sh_reg[wr_idx_reg] <= hwdata[7:0];
      // Mode is latched at V1, so only trust bytes after a V1
      if ((take & hwrite) | wr_pend_reg) settled_reg <= 1'b0;
      else if (add_in_valid && add_in_kind == 4'h1) settled_reg <= 1'b1;
    end
  end
  wire [7:0] ctl = sh_reg[8'hd3];
  wire [7:0] ln  = sh_reg[8'hd6];
  wire [7:0] k4  = sh_reg[8'hd2];
  wire       pc  = sh_reg[8'hd5][1];
  wire       ais = ctl[6];
  wire       nrm = !ais && !ctl[4];
  wire       pln = !ais && ctl[4] && !ctl[3];
  wire       sup = !ais && ctl[4] && ctl[3];
  wire       in  = settled_reg && add_in_valid;
  // ==========================================
  // Properties
  sequence s_n2; in && add_in_kind == 4'h7; endsequence
  sequence s_k4; in && add_in_kind == 4'h8; endsequence
  sequence s_ptr; in && (add_in_kind == 4'h1 || add_in_kind == 4'h2); endsequence
  property p_n2_reg;
    s_n2 ##0 (nrm && !ctl[2]) |=> add_out_byte == sh_reg[8'hd1];
  endproperty
  property p_k4_whole;
    s_k4 ##0 (nrm && pc) |=> add_out_byte == k4;
  endproperty
  property p_k4_rdi3;
    s_k4 ##0 (nrm && !pc && ln[0]) |=> add_out_byte[3:1] == $past(rdi_k4_bits);
  endproperty
  property p_k4_sym;
    s_k4 ##0 (!ais && !pln && !pc && ln[1])
      |=> add_out_byte[7:6] == $past(symmetric_k4_bits);
  endproperty
  property p_k4_keep;
    s_k4 ##0 (!ais && !pln && !pc)
      |=> {add_out_byte[5:4], add_out_byte[0]} == {k4[5:4], k4[0]};
  endproperty
  property p_tc_ais;
    s_n2 ##0 (nrm && ctl[2] && ctl[7]) |=> add_out_byte[4];
  endproperty
  property p_ais;
    in && ais |=> add_out_valid && add_out_byte == 8'hff;
  endproperty
  property p_test_ptr;
    s_ptr ##0 (!ais && ctl[5]) |=> add_out_byte ==
      ($past(add_in_kind) == 4'h1 ? sh_reg[8'hcc] : sh_reg[8'hcd]);
  endproperty
  property p_uq_zero;
    in && pln && !(add_in_kind inside {4'h1, 4'h2}) |=> add_out_byte == 8'h00;
  endproperty
  property p_sup_v5;
    in && sup && add_in_kind == 4'h5 |=> add_out_byte[3:0] == {3'b000, ln[3]};
  endproperty
  a_n2_reg: assert property (p_n2_reg) else $error("N2 not register");
  a_k4_whole: assert property (p_k4_whole) else $error("K4 not register");
  a_k4_rdi3: assert property (p_k4_rdi3) else $error("K4 RDI bits");
  a_k4_sym: assert property (p_k4_sym) else $error("K4 clock bits");
  a_k4_keep: assert property (p_k4_keep) else $error("K4 kept bits");
  a_tc_ais: assert property (p_tc_ais) else $error("N2 bit 4 not set");
  a_ais: assert property (p_ais) else $error("AIS not all ones");
  a_test_ptr: assert property (p_test_ptr) else $error("Test pointer");
  a_uq_zero: assert property (p_uq_zero) else $error("Unequipped byte");
  a_sup_v5: assert property (p_sup_v5) else $error("V5 label or RDI");
endmodule

bind tributary_add_overhead_insert add_overhead_checker i_add_overhead_checker (
  .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .add_in_valid, .add_in_kind, .add_in_byte, .rdi_k4_bits,
  .symmetric_k4_bits, .add_out_valid, .add_out_kind, .add_out_byte);

`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ==========================================
  // Signals
  logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic        add_in_valid, add_out_valid;
  logic [1:0]  htrans, sym;
  logic [2:0]  rdi;
  logic [3:0]  add_in_kind, add_out_kind;
  logic [7:0]  add_in_byte, add_out_byte, seed, t;
  logic [7:0]  rg [0:255];
  logic [15:0] v1_seen;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  int          mismatches, n_checks, frames;
  logic [7:0]  regs [7] = '{8'hcc, 8'hcd, 8'hd1, 8'hd2, 8'hd3, 8'hd5, 8'hd6};
  // Entry: K4 processor control, overhead control, line option
  logic [16:0] cfg [10] = '{
    17'h00000,
    17'h00403,
    17'h18404,
    17'h08000,
    17'h02004,
    17'h01004,
    17'h0180b,
    17'h07000,
    17'h03000,
    17'h00800
  };

  tributary_add_overhead_insert i_tributary_add_overhead_insert (
    .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .add_in_valid, .add_in_kind, .add_in_byte, .rdi_k4_bits(rdi),
    .symmetric_k4_bits(sym), .add_out_valid, .add_out_kind, .add_out_byte);
  add_bus_sink i_add_bus_sink (
    .core_clk, .rst_n, .add_out_valid, .add_out_kind, .v1_seen);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================
  // Helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rnd(output logic [7:0] v);
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    v = seed;
  endtask
  task automatic cmp_reg(input string w, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cmp_byte(input string w, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  // Ready is sampled at the falling edge, free of edge races
  task automatic wait_rdy(output logic [31:0] r);
    logic rdy;
    int   n;
    n = 0;
    do begin
      @(negedge core_clk);
      rdy = hreadyout;
      r = hrdata;
      @(posedge core_clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy(rdv);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_rdy(rdv);
    if (w) rg[i] = d;
  endtask
  function automatic logic [15:0] expect_byte(logic [3:0] k, logic [7:0] in);
    logic [7:0] c, l, v, m;
    logic       sup;
    c = rg[8'hd3];
    l = rg[8'hd6];
    sup = c[4] & c[3];
    m = 8'hff;
    v = 8'h00;
    if (c[6]) v = 8'hff;
    else if (k == 4'h1 && c[5]) v = rg[8'hcc];
    else if (k == 4'h2 && c[5]) v = rg[8'hcd];
    else if (k == 4'h1) v = l[2] ? 8'h6c : 8'h68;
    else if (k == 4'h2) v = l[2] ? 8'h4e : 8'h69;
    else if (c[4] && !sup) v = 8'h00;
    else if (k == 4'h8) begin
      v = rg[8'hd2];
      if (!rg[8'hd5][1] && l[1]) v[7:6] = sym;
      if (!rg[8'hd5][1] && l[0] && !sup) v[3:1] = rdi;
    end
    else if (k == 4'h7) v = sup ? 8'h00 :
      (!c[2] ? rg[8'hd1] : (in | {3'b000, c[7], 4'h0}));
    else if (sup && k == 4'h5) begin
      v = {7'h00, l[3]};
      m = 8'h0f;
    end
    else if (sup) v = (k == 4'h6) ? in : 8'h00;
    else m = 8'h00;
    return {m, v};
  endfunction
  // Nine bytes back to back: V1 V2 V3 V4 V5 J2 N2 K4 payload
  task automatic frame(input logic chk);
    logic [7:0]  b [0:8];
    logic [3:0]  k [0:8];
    logic [15:0] e;
    rnd(t);
    rdi <= t[2:0];
    sym <= t[4:3];
    for (int i = 0; i <= 9; i++) begin
      if (i < 9) begin
        k[i] = (i < 8) ? 4'(i + 1) : 4'h0;
        rnd(b[i]);
        add_in_valid <= 1'b1;
        add_in_kind  <= k[i];
        add_in_byte  <= b[i];
      end else begin
        add_in_valid <= 1'b0;
        add_in_byte  <= ~add_in_byte;
      end
      @(negedge core_clk);
      if (i > 0 && chk) begin
        e = expect_byte(k[i-1], b[i-1]);
        cmp_byte("kind", {4'h0, k[i-1]}, {4'h0, add_out_kind});
        cmp_byte("valid", 8'h01, {7'h00, add_out_valid});
        if (e[15:8] != 8'h00) cmp_byte("byte", e[7:0] & e[15:8], add_out_byte & e[15:8]);
      end
      @(posedge core_clk);
    end
    frames++;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {rst_n, hsel, hwrite, add_in_valid} = 4'h0;
    {haddr, hwdata, htrans, add_in_kind, add_in_byte, rdi, sym} = '0;
    seed = 8'd26;
    mismatches = 0;
    n_checks = 0;
    frames = 0;
    for (int i = 0; i < 256; i++) rg[i] = 8'h00;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (regs[j]) begin
      bus(1'b0, regs[j], 8'h00);
      cmp_reg("reset value", 32'h0, rdv);
    end
    cmp_reg("hresp", 32'h0, {31'h0, hresp});
    bus(1'b1, 8'h40, 8'hff);
    bus(1'b0, 8'h40, 8'h00);
    cmp_reg("unmapped", 32'h0, rdv);
    foreach (cfg[j]) begin
      foreach (regs[m]) begin
        rnd(t);
        if (m < 4) bus(1'b1, regs[m], t);
      end
      bus(1'b1, 8'hd3, cfg[j][15:8]);
      bus(1'b1, 8'hd5, {6'h0, cfg[j][16], 1'b0});
      bus(1'b1, 8'hd6, cfg[j][7:0]);
      foreach (regs[m]) begin
        bus(1'b0, regs[m], 8'h00);
        cmp_reg("readback", {24'h0, rg[regs[m]]}, rdv);
      end
      frame(1'b0);
      frame(1'b1);
    end
    @(negedge core_clk);
    cmp_reg("multiframes", 32'(frames), {16'h0, v1_seen});
    tally_and_finish();
  end
endmodule

`default_nettype wire
